// ===== src/rps_palette_regs.v
// Palette and module-select register bank with per-sink target routing and fades
// How it works
// - Code step is 125 uA, zero means off
// - Palette code writes above 0xC0 clamp, read back 0xC0
// - Blue set A resets to 0x28
// - Set B red, green, blue reset 0x60
// - Select byte holds two enable+palette fields
// - Disabled module targets zero, fades down smoothly
// - Enabled module targets come from selected palette
// - Select bits pick red, green, blue sets
// - Bus A module-to-sink colour routing table
// - Bus B modules 1, 2 routing table
// - Registers sit at 0x05 through 0x0B
// - Range mode scales codes, night or normal
// - Exponential fades, rate set by 3-bit field
`include "rps_defines.vh"
module rps_palette_regs (
  // Clock and reset
  input  wire        clock,
  input  wire        rst_n,
  // Register write/read port from the serial interface logic
  input  wire        wr_en,
  input  wire [7:0]  wr_addr,
  input  wire [7:0]  wr_data,
  input  wire [7:0]  rd_addr,
  output reg  [7:0]  rd_data,
  // Palette set A red/green held in other registers
  input  wire [7:0]  red_level_a,
  input  wire [7:0]  green_level_a,
  // Global range mode and fade rate from control
  input  wire [1:0]  range_mode,
  input  wire [2:0]  fade_rate,
  // Faded sink currents: [m*4+k] is module m+1 (A1..A4,B1,B2), line k+1; 8-bit, top byte of the 20-bit fade accumulator
  output reg  [191:0] sink_level
);
  reg [7:0] blue_level_a_r;
  reg [7:0] red_level_b_r;
  reg [7:0] green_level_b_r;
  reg [7:0] blue_level_b_r;
  reg [7:0] sel_a12_r;
  reg [7:0] sel_a34_r;
  reg [7:0] sel_b12_r;
  reg [7:0] rd_nxt;
  reg [7:0] wr_clamped;
  reg [6:0] tick_cnt_r;
  reg       tick_r;
  reg [3:0] fade_shift;
  // Target per module/line: module, line index
  reg [7:0] tgt [0:23];
  // Select nibbles, one per module: enable on top, palette below
  reg [23:0] sel_flat;
  integer m;

  // Only palette codes clamp; select bytes are stored exactly as written
  always @* begin
    wr_clamped = (wr_data > `RPS_CODE_MAX) ? `RPS_CODE_MAX : wr_data;
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      blue_level_a_r  <= `RPS_RST_BLU_A;
      red_level_b_r   <= `RPS_RST_SET_B;
      green_level_b_r <= `RPS_RST_SET_B;
      blue_level_b_r  <= `RPS_RST_SET_B;
      sel_a12_r       <= `RPS_RST_SEL;
      sel_a34_r       <= `RPS_RST_SEL;
      sel_b12_r       <= `RPS_RST_SEL;
    end else if (wr_en) begin
      if (wr_addr == `RPS_ADDR_BLU_A) begin
        blue_level_a_r <= wr_clamped;
      end else if (wr_addr == `RPS_ADDR_RED_B) begin
        red_level_b_r <= wr_clamped;
      end else if (wr_addr == `RPS_ADDR_GRN_B) begin
        green_level_b_r <= wr_clamped;
      end else if (wr_addr == `RPS_ADDR_BLU_B) begin
        blue_level_b_r <= wr_clamped;
      end else if (wr_addr == `RPS_ADDR_SEL_A12) begin
        sel_a12_r <= wr_data;
      end else if (wr_addr == `RPS_ADDR_SEL_A34) begin
        sel_a34_r <= wr_data;
      end else if (wr_addr == `RPS_ADDR_SEL_B12) begin
        sel_b12_r <= wr_data;
      end
    end
  end

  always @* begin
    if (rd_addr == `RPS_ADDR_BLU_A) begin
      rd_nxt = blue_level_a_r;
    end else if (rd_addr == `RPS_ADDR_RED_B) begin
      rd_nxt = red_level_b_r;
    end else if (rd_addr == `RPS_ADDR_GRN_B) begin
      rd_nxt = green_level_b_r;
    end else if (rd_addr == `RPS_ADDR_BLU_B) begin
      rd_nxt = blue_level_b_r;
    end else if (rd_addr == `RPS_ADDR_SEL_A12) begin
      rd_nxt = sel_a12_r;
    end else if (rd_addr == `RPS_ADDR_SEL_A34) begin
      rd_nxt = sel_a34_r;
    end else if (rd_addr == `RPS_ADDR_SEL_B12) begin
      rd_nxt = sel_b12_r;
    end else begin
      rd_nxt = 8'h00;
    end
  end

  // Registered read data costs a cycle but never glitches under the shifter
  always @(posedge clock) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= rd_nxt;
    end
  end

  // Each module nibble: enable at bit 3, palette at 2:0
  always @* begin
    sel_flat = {sel_b12_r[3:0], sel_b12_r[7:4], sel_a34_r[3:0], sel_a34_r[7:4], sel_a12_r[3:0], sel_a12_r[7:4]};
  end

  // Route each module's red/green/blue to its line
  // Nibbles run A1..A4, B1, B2 from the bottom, so m picks both nibble and lines
  always @* begin
    for (m = 0; m < 24; m = m + 1) begin
      tgt[m] = 8'h00;
    end
    for (m = 0; m < 6; m = m + 1) begin
      if (sel_flat[m*4+3]) begin
        case (m)
          0, 4: begin
            tgt[m*4+2] = sel_flat[m*4+2] ? red_level_b_r : red_level_a;
            tgt[m*4+1] = sel_flat[m*4+1] ? green_level_b_r : green_level_a;
            tgt[m*4+3] = sel_flat[m*4+0] ? blue_level_b_r : blue_level_a_r;
          end
          1, 5: begin
            tgt[m*4+3] = sel_flat[m*4+2] ? red_level_b_r : red_level_a;
            tgt[m*4+2] = sel_flat[m*4+1] ? green_level_b_r : green_level_a;
            tgt[m*4+0] = sel_flat[m*4+0] ? blue_level_b_r : blue_level_a_r;
          end
          2: begin
            tgt[m*4+0] = sel_flat[m*4+2] ? red_level_b_r : red_level_a;
            tgt[m*4+3] = sel_flat[m*4+1] ? green_level_b_r : green_level_a;
            tgt[m*4+1] = sel_flat[m*4+0] ? blue_level_b_r : blue_level_a_r;
          end
          default: begin
            tgt[m*4+1] = sel_flat[m*4+2] ? red_level_b_r : red_level_a;
            tgt[m*4+0] = sel_flat[m*4+1] ? green_level_b_r : green_level_a;
            tgt[m*4+2] = sel_flat[m*4+0] ? blue_level_b_r : blue_level_a_r;
          end
        endcase
      end
    end
  end

  // One shared divider serves all 24 filters instead of one counter each
  // Limitation: fade time constants only approximate the nominal settings
  // Shared fade tick every 1 us; slower rates use a larger shift per step
  always @(posedge clock) begin
    if (!rst_n) begin
      tick_cnt_r <= 7'h00;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r == `RPS_FADE_TICK_CYC - 1) begin
      tick_cnt_r <= 7'h00;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 7'h01;
      tick_r     <= 1'b0;
    end
  end

  always @* begin
    fade_shift = `RPS_FADE_SHIFT_MIN + {1'b0, fade_rate};
  end

  // One first-order filter per line; the target is scaled by range first
  genvar g;
  generate
    for (g = 0; g < 24; g = g + 1) begin : g_fade
      reg [11:0] goal;
      reg [19:0] acc_r;
      reg [19:0] delta;
      always @* begin
        // Codes map to 16 steps/code in normal range, 1 in night range
        if (range_mode == `RPS_RANGE_NORMAL) begin
          goal = {tgt[g], 4'h0};
        end else if (range_mode == `RPS_RANGE_NIGHT) begin
          goal = {4'h0, tgt[g]};
        end else begin
          // Undecoded range codes park every target at zero
          goal = 12'h000;
        end
        if ({goal, 8'h00} >= acc_r) begin
          delta = ({goal, 8'h00} - acc_r) >> fade_shift;
          if (delta == 20'h0 && {goal, 8'h00} != acc_r) delta = 20'h1;
        end else begin
          delta = (acc_r - {goal, 8'h00}) >> fade_shift;
          if (delta == 20'h0) delta = 20'h1;
        end
      end
      // The one-LSB minimum step lets the filter land exactly on its goal
      // Ramp, never step, including fades to zero on disable
      always @(posedge clock) begin
        if (!rst_n) begin
          acc_r <= 20'h0_0000;
        end else if (tick_r) begin
          if ({goal, 8'h00} >= acc_r) begin
            acc_r <= acc_r + delta;
          end else begin
            acc_r <= acc_r - delta;
          end
        end
      end
      always @(posedge clock) begin
        if (!rst_n) begin
          sink_level[g*8+7:g*8] <= 8'h00;
        end else begin
          sink_level[g*8+7:g*8] <= acc_r[19:12];
        end
      end
    end
  endgenerate
endmodule

// ===== src/rps_defines.vh
// Register offsets, reset values and field positions for the palette/select bank
`ifndef RPS_DEFINES_VH
`define RPS_DEFINES_VH
`define RPS_ADDR_BLU_A     8'h05
`define RPS_ADDR_RED_B     8'h06
`define RPS_ADDR_GRN_B     8'h07
`define RPS_ADDR_BLU_B     8'h08
`define RPS_ADDR_SEL_A12   8'h09
`define RPS_ADDR_SEL_A34   8'h0a
`define RPS_ADDR_SEL_B12   8'h0b
`define RPS_RST_BLU_A      8'h28
`define RPS_RST_SET_B      8'h60
`define RPS_RST_SEL        8'h00
`define RPS_CODE_MAX       8'hc0
`define RPS_FIRST_ON_BIT   7
`define RPS_SECOND_ON_BIT  3
`define RPS_RANGE_NIGHT    2'b01
`define RPS_RANGE_NORMAL   2'b10
`define RPS_FADE_SHIFT_MIN 4'h5
`define RPS_FADE_TICK_NS   1000
`define RPS_FADE_TICK_CYC  (`RPS_FADE_TICK_NS / 8)
`endif

// ===== verif/rps_palette_regs_props.sv
// Port assertions for the palette and select register bank
module rps_props (
  // Clock and reset
  input wire logic         clock,
  input wire logic         rst_n,
  // Register port
  input wire logic         wr_en,
  input wire logic [7:0]   wr_addr,
  input wire logic [7:0]   wr_data,
  input wire logic [7:0]   rd_addr,
  input wire logic [7:0]   rd_data,
  // Faded sink levels
  input wire logic [191:0] sink_level
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire hit = wr_en && rd_addr == wr_addr;
  wire lvl = hit && wr_addr > 8'h04 && wr_addr < 8'h09;
  wire sel = hit && wr_addr > 8'h08 && wr_addr < 8'h0c;
  clamp_read_a: assert property (lvl && wr_data > 8'hc0 ##1 !wr_en && $stable(rd_addr) |=> rd_data == 8'hc0)
    else $error("clamp readback");
  level_read_a: assert property (lvl && wr_data <= 8'hc0 ##1 !wr_en && $stable(rd_addr) |=> rd_data == $past(wr_data, 2))
    else $error("level readback");
  select_read_a: assert property (sel ##1 !wr_en && $stable(rd_addr) |=> rd_data == $past(wr_data, 2))
    else $error("select readback");
  unmapped_read_a: assert property (rd_addr < 8'h05 || rd_addr > 8'h0b |=> rd_data == 8'h00)
    else $error("unmapped read");
  read_hold_a: assert property (!wr_en ##1 !wr_en && $stable(rd_addr) |=> $stable(rd_data)) else $error("read hold");
  // Fades move only on the slow tick, so a step is never followed at once by another
  fade_tick_a: assert property ($changed(sink_level) |=> $stable(sink_level) [*8]) else $error("fade step");
  reset_dark_a: assert property ($rose(rst_n) |-> sink_level == '0) else $error("sinks lit at reset");
  reset_read_a: assert property ($rose(rst_n) |-> rd_data == 8'h00) else $error("read data at reset");
endmodule
bind rps_palette_regs rps_props u_props (.clock(clock), .rst_n(rst_n), .wr_en(wr_en), .wr_addr(wr_addr),
  .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data), .sink_level(sink_level));

// ===== verif/rps_host_model.sv
// Host model issuing register writes and reads to the bank
module rps_host_model (
  // Clock
  input wire logic       clock,
  // Register port
  output logic           wr_en,
  output logic [7:0]     wr_addr,
  output logic [7:0]     wr_data,
  output logic [7:0]     rd_addr,
  input wire logic [7:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    wr_en = 1'b0;
    wr_addr = 8'h00;
    wr_data = 8'h00;
    rd_addr = 8'h00;
  end
  // Address and data are inverted after the strobe so stale values are never relied on
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    wr_en <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge clock);
    wr_en <= 1'b0;
    wr_addr <= ~a;
    wr_data <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    rd_addr <= a;
    @(posedge clock);
    #1 d = rd_data;
  endtask
endmodule

// ===== verif/rps_palette_regs_tb_top.sv
// Self-checking bench for the palette and select register bank
module rps_palette_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst_n, wr_en;
  logic [7:0] wr_addr, wr_data, rd_addr, rd_data, v, s;
  logic [1:0] range_mode = 2'b10;
  logic [2:0] fade_rate = 3'b000;
  logic [191:0] sink_level;
  int err_total, num_checks;
  // Red, green, blue lines of modules A1..A4, B1, B2; palette red/green/blue set A then set B
  int rl[6] = '{3, 4, 1, 2, 3, 4};
  int gl[6] = '{2, 3, 4, 1, 2, 3};
  int bl[6] = '{4, 1, 2, 3, 4, 1};
  logic [7:0] pa[6] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'hc0};
  logic [3:0] sel[6] = '{4'hc, 4'hb, 4'ha, 4'hd, 4'he, 4'h7};
  logic [7:0] cv[5] = '{8'hff, 8'hc1, 8'hc0, 8'h01, 8'h00};
  `define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end
  rps_host_model host (.clock(clock), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr),
    .rd_data(rd_data));
  rps_palette_regs uut (.clock(clock), .rst_n(rst_n), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_addr(rd_addr), .rd_data(rd_data), .red_level_a(pa[0]), .green_level_a(pa[1]), .range_mode(range_mode),
    .fade_rate(fade_rate), .sink_level(sink_level));
  function automatic logic [7:0] want(int m, int k);
    if (!sel[m][3]) return 8'h00;
    if (k == rl[m]) return sel[m][2] ? pa[3] : pa[0];
    if (k == gl[m]) return sel[m][1] ? pa[4] : pa[1];
    if (k == bl[m]) return sel[m][0] ? pa[5] : pa[2];
    return 8'h00;
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Settling the fades dominates the run of about 635 us; limit is about a fifth above it
  initial begin
    #760000;
    err_total++;
    conclude();
  end
  initial begin
    rst_n = 1'b0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    for (int a = 4; a < 13; a++) begin
      host.rd(a[7:0], v);
      `CHK("reset value", (a == 5) ? 8'h28 : (a > 5 && a < 9) ? 8'h60 : 8'h00, v)
    end
    $display("test reset values done");
    for (int a = 5; a < 9; a++) foreach (cv[i]) begin
      host.wr(a[7:0], cv[i]);
      host.rd(a[7:0], v);
      `CHK("level write", (cv[i] > 8'hc0) ? 8'hc0 : cv[i], v)
    end
    $display("test level clamp done");
    host.wr(8'h0b, 8'hff);
    host.rd(8'h0b, v);
    `CHK("select raw", 8'hff, v)
    for (int i = 2; i < 6; i++) host.wr(8'h03 + i[7:0], (i == 5) ? 8'hff : pa[i]);
    for (int i = 0; i < 3; i++) host.wr(8'h09 + i[7:0], {sel[2 * i], sel[2 * i + 1]});
    host.rd(8'h0b, v);
    `CHK("select byte", {sel[4], sel[5]}, v)
    repeat (55000) @(posedge clock);
    for (int m = 0; m < 6; m++) for (int k = 1; k < 5; k++)
      `CHK("sink level", want(m, k), sink_level[(m * 4 + k - 1) * 8 +: 8])
    $display("test routing done");
    sel[0] = 4'h4;
    host.wr(8'h09, {sel[0], sel[1]});
    repeat (300) @(posedge clock);
    s = sink_level[16 +: 8];
    `CHK("fade down", 1'b1, s != 8'h00 && s < 8'h44)
    $display("test disable fade done");
    // Night range divides every target by 16; fades settle from above
    range_mode <= 2'b01;
    repeat (24000) @(posedge clock);
    for (int m = 0; m < 6; m++) for (int k = 1; k < 5; k++)
      `CHK("night level", want(m, k) >> 4, sink_level[(m * 4 + k - 1) * 8 +: 8])
    $display("test night range done");
    conclude();
  end
endmodule
